/* File: core/cap_sense_regs.vh */
// Register indices, field positions, reset values and counts of the capacitive-sense scanner.
`ifndef CAP_SENSE_REGS_VH
`define CAP_SENSE_REGS_VH
// Register indices; byte address is four times the index.
`define IDX_CONFIG     8'hd0
`define IDX_MUX        8'hd1
`define IDX_CTRL       8'hd2
`define IDX_DATA_LOW   8'hd3
`define IDX_DATA_HIGH  8'hd4
`define IDX_THR_LOW    8'hd5
`define IDX_THR_HIGH   8'hd6
`define IDX_INT_STATUS 8'hd7
`define IDX_INT_MASK   8'hd8
`define IDX_SCAN_START 8'hdd
`define IDX_SCAN_END   8'hde
// Field positions.
`define CFG_MODE_HI    6
`define CFG_MODE_LO    4
`define CFG_ACU_HI     2
`define CFG_ACU_LO     0
`define MODE_AUTOSCAN  3'h7
`define MODE_SOFTWARE  3'h0
`define CTRL_BUSY      4
`define CTRL_DONE      5
`define INT_DONE       0
`define INT_GT         1
// Reset values.
`define RST_BYTE       8'h00
`define RST_CHAN       5'h00
// Widths.
`define DATA_W         16
`define SUM_W          22
`define CNT_W          6
// Last sample index and divide shift for each accumulate setting.
`define LAST_1         6'h00
`define LAST_4         6'h03
`define LAST_8         6'h07
`define LAST_16        6'h0f
`define LAST_32        6'h1f
`define LAST_64        6'h3f
`define SHIFT_1        3'h0
`define SHIFT_4        3'h2
`define SHIFT_8        3'h3
`define SHIFT_16       3'h4
`define SHIFT_32       3'h5
`define SHIFT_64       3'h6
`endif

/* File: core/cap_sense_scan.v */
// Capacitive-sense auto-scan sequencer and accumulator with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "cap_sense_regs.vh"
module cap_sense_scan (
  input  wire        MCLK,        // System clock, 125 MHz.
  input  wire        RESET,       // Asynchronous reset, active high.
  input  wire        HSEL,        // AHB slave select.
  input  wire [31:0] HADDR,       // AHB address.
  input  wire [1:0]  HTRANS,      // AHB transfer type.
  input  wire        HWRITE,      // AHB write.
  input  wire [2:0]  HSIZE,       // AHB size, word only.
  input  wire [31:0] HWDATA,      // AHB write data.
  input  wire        HREADY,      // AHB bus ready.
  output reg  [31:0] HRDATA,      // AHB read data.
  output reg         HREADYOUT,   // AHB slave ready.
  output reg         HRESP,       // AHB response, always OKAY.
  output reg         CONV_START,  // One-cycle request to the analog front end.
  output reg  [4:0]  CONV_CHANNEL,// Channel selected by the multiplexer.
  input  wire        CONV_DONE,   // Front end conversion done, asynchronous level.
  input  wire [15:0] CONV_DATA,   // Front end conversion result.
  input  wire [31:0] ANALOG_CFG,  // Pins configured as analog inputs.
  output reg  [31:0] GROUND_EN,   // Channels grounded during conversion.
  input  wire        DEBUG_HALT,  // Core halted for debugging.
  input  wire        SUSPEND,     // Device in suspend.
  output reg         WAKE,        // Wake request out of suspend.
  output reg         IRQ          // Level interrupt.
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_WAIT  = 2'h2;

  reg  [1:0]  state_q;
  reg  [7:0]  config_q;
  reg  [4:0]  start_q;
  reg  [4:0]  end_q;
  reg  [15:0] data_q;
  reg  [15:0] thr_q;
  reg  [1:0]  status_q;
  reg  [1:0]  mask_q;
  reg         done_flag_q;
  reg         scan_q;
  reg         halt_seen_q;
  reg  [21:0] sum_q;
  reg  [5:0]  cnt_q;
  reg         done_s1_q;
  reg         done_s2_q;
  reg         done_s3_q;
  reg  [15:0] cdata_s1_q;
  reg  [15:0] cdata_s2_q;
  reg         wr_pend_q;
  reg         rd_pend_q;
  reg  [7:0]  addr_q;

  wire        autoscan  = (config_q[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_AUTOSCAN);
  wire        sw_mode   = (config_q[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_SOFTWARE);
  wire        acc_phase = HSEL && HREADY && HTRANS[1];
  wire        wr_now    = wr_pend_q;
  wire [7:0]  wbyte     = HWDATA[7:0];
  wire        conv_evt  = done_s2_q && !done_s3_q;
  wire [21:0] sum_new   = sum_q + {6'h00, cdata_s2_q};

  // Sample count and divide shift from the accumulate select.
  reg  [5:0]  last_cnt;
  reg  [2:0]  shift;
  // Codes 6 and 7 fall to the deepest setting so no code leaves the divide undefined.
  always @* begin
    case (config_q[`CFG_ACU_HI:`CFG_ACU_LO])
      3'h0: begin
        last_cnt = `LAST_1;
        shift    = `SHIFT_1;
      end
      3'h1: begin
        last_cnt = `LAST_4;
        shift    = `SHIFT_4;
      end
      3'h2: begin
        last_cnt = `LAST_8;
        shift    = `SHIFT_8;
      end
      3'h3: begin
        last_cnt = `LAST_16;
        shift    = `SHIFT_16;
      end
      3'h4: begin
        last_cnt = `LAST_32;
        shift    = `SHIFT_32;
      end
      default: begin
        last_cnt = `LAST_64;
        shift    = `SHIFT_64;
      end
    endcase
  end

  // A done edge seen outside a wait is stray; it must not count or raise any event.
  wire        acc_done = conv_evt && (state_q == ST_WAIT) && (cnt_q == last_cnt);
  wire [21:0] quot22   = sum_new >> shift;
  wire [15:0] quot     = quot22[15:0];
  wire        gt       = (quot > thr_q);
  // Wrap is an equality test, so a select outside the range runs on until it meets the end.
  wire        wrap     = (CONV_CHANNEL == end_q);

  // Ground mask per channel: analog pins inside the scan range, except the one converting.
  wire [31:0] gnd_d;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : gnd_gen
      assign gnd_d[g] = scan_q && ANALOG_CFG[g] && (g >= start_q) && (g <= end_q) &&
                        (g != CONV_CHANNEL);
    end
  endgenerate

  // The done level crosses from the front end; the data is held steady by the front end
  // while done is high, so its two-stage copy is settled by the time the edge is seen.
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      done_s1_q  <= 1'b0;
      done_s2_q  <= 1'b0;
      done_s3_q  <= 1'b0;
      cdata_s1_q <= 16'h0000;
      cdata_s2_q <= 16'h0000;
    end else begin
      done_s1_q  <= CONV_DONE;
      done_s2_q  <= done_s1_q;
      done_s3_q  <= done_s2_q;
      cdata_s1_q <= CONV_DATA;
      cdata_s2_q <= cdata_s1_q;
    end
  end

  // Bus slave: writes take effect at the end of the data phase; reads add one wait state
  // so a read that directly follows a write returns the new value.
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
    end else begin
      HRESP <= 1'b0;
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        HREADYOUT <= 1'b1;
        case (addr_q)
          `IDX_CONFIG:     HRDATA <= {24'h000000, config_q};
          `IDX_MUX:        HRDATA <= {27'h0, CONV_CHANNEL};
          `IDX_CTRL:       HRDATA <= {26'h0, done_flag_q, (state_q != ST_IDLE),
                                      4'h0};
          `IDX_DATA_LOW:   HRDATA <= {24'h000000, data_q[7:0]};
          `IDX_DATA_HIGH:  HRDATA <= {24'h000000, data_q[15:8]};
          `IDX_THR_LOW:    HRDATA <= {24'h000000, thr_q[7:0]};
          `IDX_THR_HIGH:   HRDATA <= {24'h000000, thr_q[15:8]};
          `IDX_INT_STATUS: HRDATA <= {30'h0, status_q};
          `IDX_INT_MASK:   HRDATA <= {30'h0, mask_q};
          `IDX_SCAN_START: HRDATA <= {27'h0, start_q};
          `IDX_SCAN_END:   HRDATA <= {27'h0, end_q};
          default:         HRDATA <= 32'h0000_0000;
        endcase
      end else if (acc_phase) begin
        addr_q    <= HADDR[9:2];
        wr_pend_q <= HWRITE;
        rd_pend_q <= !HWRITE;
        HREADYOUT <= HWRITE;
      end else begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // Configuration registers written by software.
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      config_q <= `RST_BYTE;
      start_q  <= `RST_CHAN;
      end_q    <= `RST_CHAN;
      thr_q    <= 16'h0000;
      mask_q   <= 2'h0;
    end else if (wr_now) begin
      case (addr_q)
        `IDX_CONFIG:    config_q    <= wbyte;
        `IDX_THR_LOW:   thr_q[7:0]  <= wbyte;
        `IDX_THR_HIGH:  thr_q[15:8] <= wbyte;
        `IDX_INT_MASK:  mask_q      <= wbyte[1:0];
        `IDX_SCAN_START: start_q    <= wbyte[4:0];
        `IDX_SCAN_END:  end_q       <= wbyte[4:0];
        default: ;
      endcase
    end
  end

  // Busy is a write-one strobe; writing zero to it does nothing to a running sequence.
  wire busy_wr = wr_now && (addr_q == `IDX_CTRL) && wbyte[`CTRL_BUSY];

  // Conversion sequencer, accumulator and channel stepping.
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state_q      <= ST_IDLE;
      scan_q       <= 1'b0;
      halt_seen_q  <= 1'b0;
      sum_q        <= 22'h0;
      cnt_q        <= 6'h00;
      data_q       <= 16'h0000;
      CONV_START   <= 1'b0;
      CONV_CHANNEL <= `RST_CHAN;
    end else begin
      CONV_START <= 1'b0;
      if (!autoscan) begin
        scan_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          halt_seen_q <= 1'b0;
          if (busy_wr && (autoscan || sw_mode)) begin
            sum_q   <= 22'h0;
            cnt_q   <= 6'h00;
            state_q <= ST_START;
            if (autoscan) begin
              scan_q       <= 1'b1;
              CONV_CHANNEL <= start_q;
            end
          end
        end
        ST_START: begin
          CONV_START <= 1'b1;
          state_q    <= ST_WAIT;
        end
        ST_WAIT: begin
          // A halt only marks the rotation; the scan still runs to the wrap so that
          // every channel of the range gets its turn before it stops.
          if (scan_q && DEBUG_HALT) begin
            halt_seen_q <= 1'b1;
          end
          if (conv_evt && !acc_done) begin
            sum_q   <= sum_new;
            cnt_q   <= cnt_q + 6'h01;
            state_q <= ST_START;
          end else if (acc_done) begin
            sum_q  <= 22'h0;
            cnt_q  <= 6'h00;
            data_q <= quot;
            if (!scan_q || gt) begin
              scan_q  <= 1'b0;
              state_q <= ST_IDLE;
            end else if (wrap) begin
              CONV_CHANNEL <= start_q;
              if (halt_seen_q || (scan_q && DEBUG_HALT)) begin
                scan_q  <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_START;
              end
            end else begin
              CONV_CHANNEL <= CONV_CHANNEL + 5'h01;
              state_q      <= ST_START;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Software writes to the select come last so they win over the sequencer.
      if (wr_now && (addr_q == `IDX_MUX)) begin
        CONV_CHANNEL <= wbyte[4:0];
      end
      if (wr_now && (addr_q == `IDX_SCAN_START) && autoscan) begin
        CONV_CHANNEL <= wbyte[4:0];
      end
    end
  end

  // Event flags: hardware set wins over a software clear in the same cycle.
  wire gt_evt = acc_done && gt;
  wire [1:0] evt = {gt_evt, acc_done};
  wire [1:0] w1c = (wr_now && (addr_q == `IDX_INT_STATUS)) ? wbyte[1:0] : 2'h0;
  wire ctrl_wr = wr_now && (addr_q == `IDX_CTRL);
  wire [1:0] status_d;

  // One sticky bit per event; the event term is ored last so a clear never hides it.
  genvar e;
  generate
    for (e = 0; e < 2; e = e + 1) begin : flag_gen
      assign status_d[e] = evt[e] | (status_q[e] & ~w1c[e]);
    end
  endgenerate

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      status_q    <= 2'h0;
      done_flag_q <= 1'b0;
      IRQ         <= 1'b0;
      WAKE        <= 1'b0;
      GROUND_EN   <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
      if (acc_done) begin
        done_flag_q <= 1'b1;
      end else if (ctrl_wr && !wbyte[`CTRL_DONE]) begin
        done_flag_q <= 1'b0;
      end
      // The interrupt follows the next flag value so it rises with the flag, not after it.
      IRQ <= |(status_d & mask_q);
      // The scan keeps stepping in suspend; only a greater-than result raises wake.
      if (!SUSPEND) begin
        WAKE <= 1'b0;
      end else if (gt_evt && scan_q) begin
        WAKE <= 1'b1;
      end
      GROUND_EN <= gnd_d;
    end
  end

endmodule // cap_sense_scan

/* File: verif/cap_sense_scan_props.sv */
// Checker of bus timing, grounding, conversion pacing and wake of the scanner.
`timescale 1ns/1ps
module cap_sense_scan_props (
  input logic        MCLK,         // Clock.
  input logic        RESET,        // Reset.
  input logic        HSEL,         // Select.
  input logic [1:0]  HTRANS,       // Transfer type.
  input logic        HWRITE,       // Write.
  input logic        HREADY,       // Bus ready.
  input logic        HREADYOUT,    // Slave ready.
  input logic        HRESP,        // Response.
  input logic        CONV_START,   // Start pulse.
  input logic [4:0]  CONV_CHANNEL, // Mux select.
  input logic [31:0] ANALOG_CFG,   // Analog pins.
  input logic [31:0] GROUND_EN,    // Grounded channels.
  input logic        SUSPEND,      // Suspend.
  input logic        WAKE          // Wake.
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire take = HSEL && HREADY && HTRANS[1];
  chk_resp_okay: assert property (HRESP == 1'b0) else $error("response not OKAY");
  chk_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not two cycles");
  chk_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write inserted a wait");
  chk_ground_range: assert property (CONV_START |=>
    ((GROUND_EN & ~ANALOG_CFG) == 32'h0) && !GROUND_EN[CONV_CHANNEL])
    else $error("wrong channels grounded");
  chk_chan_steady: assert property (CONV_START |=> $stable(CONV_CHANNEL)[*3])
    else $error("select moved during conversion");
  chk_conv_spacing: assert property (CONV_START |=> !CONV_START[*4])
    else $error("start before result");
  chk_wake_clear: assert property (!SUSPEND |=> !WAKE)
    else $error("wake outside suspend");
  chk_wake_rise: assert property ($rose(WAKE) |-> $past(SUSPEND))
    else $error("wake rose without suspend");
endmodule // cap_sense_scan_props
bind cap_sense_scan cap_sense_scan_props i_props (.MCLK(MCLK), .RESET(RESET), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL), .ANALOG_CFG(ANALOG_CFG),
  .GROUND_EN(GROUND_EN), .SUSPEND(SUSPEND), .WAKE(WAKE));

/* File: verif/cap_sense_front_model.sv */
// Behavioural analog front end answering each start with a channel-tagged sample.
`timescale 1ns/1ps
module cap_sense_front_model (
  input  logic        clk,    // Clock.
  input  logic        start,  // Conversion request.
  input  logic [4:0]  chan,   // Selected channel.
  input  logic        slow,   // Stretch each conversion.
  input  logic        rewind, // Restart the sample counter.
  output logic        done,   // Result ready.
  output logic [15:0] data    // Result.
);
  logic [7:0] k = 8'h00;
  logic [4:0] c;
  initial begin
    done = 1'b0;
    data = 16'hffff;
  end
  // The low byte counts samples so that every averaging depth gives its own result.
  always @(posedge clk) begin
    if (rewind) k <= 8'h00;
    if (start) begin
      c = chan;
      repeat (slow ? 9 : 2) @(posedge clk);
      data <= {3'h0, c, k};
      @(posedge clk);
      done <= 1'b1;
      repeat (2) @(posedge clk);
      done <= 1'b0;
      data <= ~{3'h0, c, k};
      k <= k + 8'h01;
    end
  end
endmodule // cap_sense_front_model

/* File: verif/cap_sense_scan_bench.sv */
// Register-level bench of the scanner with the front end model.
`timescale 1ns/1ps
`include "cap_sense_regs.vh"
module cap_sense_scan_bench;
  logic        MCLK = 0, RESET = 1, HWRITE = 0, DEBUG_HALT = 0, SUSPEND = 0;
  logic        slow = 0, rewind = 0, st_d = 0;
  logic [1:0]  HTRANS = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, ANALOG_CFG = 32'h6, rd, g1;
  wire  [31:0] HRDATA, GROUND_EN;
  wire         HREADYOUT, HRESP, CONV_START, CONV_DONE, WAKE, IRQ;
  wire  [4:0]  CONV_CHANNEL;
  wire  [15:0] CONV_DATA;
  logic [4:0]  q[$];
  int          num_errors = 0, n_tests = 0, a, n;
  always #4 MCLK = ~MCLK;
  cap_sense_scan i_dut (.MCLK(MCLK), .RESET(RESET), .HSEL(1'b1), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_START(CONV_START),
    .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
    .ANALOG_CFG(ANALOG_CFG), .GROUND_EN(GROUND_EN), .DEBUG_HALT(DEBUG_HALT),
    .SUSPEND(SUSPEND), .WAKE(WAKE), .IRQ(IRQ));
  cap_sense_front_model i_fe (.clk(MCLK), .start(CONV_START), .chan(CONV_CHANNEL),
    .slow(slow), .rewind(rewind), .done(CONV_DONE), .data(CONV_DATA));
  always @(posedge MCLK) begin
    st_d <= CONV_START;
    if (CONV_START) q.push_back(CONV_CHANNEL);
    if (st_d && CONV_CHANNEL == 5'h01) g1 <= GROUND_EN;
  end
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hwait;
    int t;
    t = 0;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) begin
      t++;
      if (t > 50) begin
        num_errors++;
        wrap_up;
      end
      @(posedge MCLK);
    end
  endtask
  // Address phase held until ready, then data phase held until ready again.
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {22'h0, idx, 2'b00};
    hwait;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    hwait;
    rd = HRDATA;
  endtask
  task rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask
  task idle;
    int t;
    t = 0;
    do begin
      bus(1'b0, `IDX_CTRL, 32'h0);
      t++;
    end while (rd[`CTRL_BUSY] !== 1'b0 && t < 400);
    if (t >= 400) begin
      num_errors++;
      wrap_up;
    end
  endtask
  task kick;
    rewind <= 1'b1;
    @(posedge MCLK);
    rewind <= 1'b0;
    q.delete();
    bus(1'b1, `IDX_CTRL, 32'h10);
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    rchk("start reset", `IDX_SCAN_START, 32'h0);
    bus(1'b1, `IDX_SCAN_START, 32'hff);
    rchk("start width", `IDX_SCAN_START, 32'h1f);
    rchk("mux no copy", `IDX_MUX, 32'h0);
    bus(1'b1, 8'h40, 32'h5a);
    rchk("unmapped", 8'h40, 32'h0);
    bus(1'b1, `IDX_INT_MASK, 32'h1);
    for (a = 0; a < 6; a++) begin
      n = (a == 0) ? 1 : (2 << a);
      bus(1'b1, `IDX_CONFIG, a);
      bus(1'b1, `IDX_MUX, a + 4);
      kick;
      idle;
      chk("done flag", 32'h1, rd[`CTRL_DONE]);
      chk("samples", n, q.size());
      rchk("avg low", `IDX_DATA_LOW, (n - 1) / 2);
      rchk("avg high", `IDX_DATA_HIGH, a + 4);
      rchk("mux kept", `IDX_MUX, a + 4);
      rchk("status", `IDX_INT_STATUS, 32'h3);
      chk("irq on", 32'h1, IRQ);
      bus(1'b1, `IDX_INT_STATUS, 32'h3);
      rchk("status clr", `IDX_INT_STATUS, 32'h0);
      chk("irq off", 32'h0, IRQ);
    end
    bus(1'b1, `IDX_CONFIG, 32'h10);
    kick;
    idle;
    chk("other mode", 32'h0, q.size());
    bus(1'b1, `IDX_THR_LOW, 32'hff);
    bus(1'b1, `IDX_THR_HIGH, 32'hff);
    bus(1'b1, `IDX_INT_MASK, 32'h2);
    bus(1'b1, `IDX_CONFIG, 32'h70);
    bus(1'b1, `IDX_SCAN_END, 32'h3);
    bus(1'b1, `IDX_SCAN_START, 32'h1);
    rchk("mux copy", `IDX_MUX, 32'h1);
    kick;
    n = 0;
    while (q.size() < 4 && n < 2000) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      wrap_up;
    end
    DEBUG_HALT <= 1'b1;
    idle;
    DEBUG_HALT <= 1'b0;
    for (a = 0; a < 4; a++) chk("scan order", (a % 3) + 1, q[a]);
    rchk("halt at start", `IDX_MUX, 32'h1);
    chk("halt count", 32'h6, q.size());
    chk("grounded", 32'h4, g1);
    rchk("no gt", `IDX_INT_STATUS, 32'h1);
    chk("irq masked", 32'h0, IRQ);
    bus(1'b1, `IDX_THR_HIGH, 32'h03);
    bus(1'b1, `IDX_THR_LOW, 32'h00);
    bus(1'b1, `IDX_INT_STATUS, 32'h3);
    SUSPEND <= 1'b1;
    slow <= 1'b1;
    kick;
    idle;
    chk("stop count", 32'h3, q.size());
    rchk("mux held", `IDX_MUX, 32'h3);
    rchk("gt data", `IDX_DATA_LOW, 32'h2);
    chk("wake", 32'h1, WAKE);
    chk("irq gt", 32'h1, IRQ);
    SUSPEND <= 1'b0;
    repeat (2) @(posedge MCLK);
    chk("wake off", 32'h0, WAKE);
    wrap_up;
  end
endmodule // cap_sense_scan_bench
